// >>> mac_pkg.sv
`default_nettype none
// ****************************************************************
// shared constants of the selector / converter control
// ****************************************************************
package mac_pkg;
    // clock and link widths
    localparam int unsigned SYS_CLK_PERIOD_NS = 20;
    localparam int unsigned WORD_W            = 4;
    localparam int unsigned RES_W             = 12;
    localparam int unsigned NUM_CH            = 8;
    localparam int unsigned NUM_CH_SMALL      = 4;

    // input word layout, first bit shifted in ends at the top
    localparam int unsigned WORD_EN_BIT  = 3;
    localparam int unsigned WORD_ADDR_HI = 2;

    // conversion figures in shift clock cycles
    localparam logic [3:0] CONV_CYCLES  = 4'hC;
    localparam logic [3:0] LAST_BIT_IDX = 4'hB;
    localparam logic [3:0] TAIL_END     = 4'hC;

    // switch timing in ns, cycle counts rounded up
    localparam int unsigned SWITCH_OFF_DELAY_NS = 100;
    localparam int unsigned BREAK_INTERVAL_NS   = 150;
    localparam int unsigned CHANNEL_SETTLE_NS   = SWITCH_OFF_DELAY_NS + BREAK_INTERVAL_NS;
    localparam logic [7:0] SWITCH_OFF_CYC =
        8'((SWITCH_OFF_DELAY_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS);
    localparam logic [7:0] CHANNEL_SETTLE_CYC =
        8'((CHANNEL_SETTLE_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS);

    // synchroniser lanes and their reset levels (chip selects idle high)
    localparam int unsigned SYNC_W    = 5;
    localparam int unsigned L_CS_SEL  = 0;
    localparam int unsigned L_CS_CONV = 1;
    localparam int unsigned L_SCLK    = 2;
    localparam int unsigned L_DIN     = 3;
    localparam int unsigned L_CMP     = 4;
    localparam logic [4:0] SYNC_RST   = 5'h03;

    // reset values
    localparam logic [3:0]  WORD_RST = 4'h0;
    localparam logic [11:0] CODE_RST = 12'h000;
    localparam logic [7:0]  TMR_RST  = 8'h00;

    typedef enum logic [1:0] {SW_HOLD, SW_WAIT_OFF, SW_WAIT_ON} mac_sw_e;
    typedef enum logic [1:0] {CV_DOWN, CV_SAMPLE, CV_CONVERT, CV_TAIL} mac_cv_e;
endpackage : mac_pkg
`default_nettype wire

// >>> mac_muxed_adc_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
// How it works
// [R1] with enable set, next three bits pick the channel; small variant only top bit 0
// [R2] enable clear: address ignored, every channel switched off
// [R3] result is unipolar straight binary, zero volts all zeros
// [R4] shared data wire is driven after select falls, before sixth falling edge
// [R5] host drives the shared wire only while select is high
// [R6] selector and converter selects act independently; repeat conversions on one channel
// [R7] after conversion, bias, comparator, reference released; LSB-first copy then zeroes
// [R8] converter select high: fully powered down, selector word still loads
// [R9] sampling from settle delay after select fall until second falling edge
// [R10] conversion lasts exactly twelve shift clock cycles from the hold edge
// [R11] sampling spans at least one and a half shift clock cycles
// [R12] at window end capacitor moves to negative input, conversion starts
// [R13] host keeps shift clock at or below 320kHz
// [R14] first word bit is enable; channel on after settle, off after off delay
// [R15] rising edges load word while select high, last four bits kept
// [R16] bits launched on falling shift edge, sampled on rising edge
// [R17] one null bit precedes the result; channel stays on until next select fall
// [R18] result sent MSB first then LSB-first copy; output off while select high
module mac_muxed_adc_ctrl
    import mac_pkg::*;
#(
    parameter bit EIGHT_CHANNELS = 1'b1
) (
    // clock and reset
    input  wire logic              sys_clk,
    input  wire logic              rstn,
    // serial link pins
    input  wire logic              selector_chip_select_n,
    input  wire logic              converter_chip_select_n,
    input  wire logic              shift_clk,
    input  wire logic              serial_in,
    output logic                   serial_out,
    output logic                   serial_out_oe,
    // analogue selector switches
    output logic [NUM_CH-1:0]      channel_on,
    // sample-and-hold and converter core
    input  wire logic              comparator_high,
    output logic                   sample_on,
    output logic                   cap_to_negative_input,
    output logic                   converter_power_on,
    output logic                   reference_connect,
    output logic [RES_W-1:0]       dac_trial_code
);

    // ****************************************************************
    // pin synchronisers
    // ****************************************************************
    logic [SYNC_W-1:0] pin_raw;
    logic [SYNC_W-1:0] s1_q, s2_q, s3_q, filt_q, filt_d, prev_q;

    assign pin_raw = {comparator_high, serial_in, shift_clk, converter_chip_select_n, selector_chip_select_n};

    // a change counts once second and third stage agree
    genvar gi;
    generate
        for (gi = 0; gi < SYNC_W; gi++) begin : g_filt
            assign filt_d[gi] = (s2_q[gi] == s3_q[gi]) ? s3_q[gi] : filt_q[gi];
        end
    endgenerate

    // three-stage chain, filtered level and its previous value
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            s1_q   <= SYNC_RST;
            s2_q   <= SYNC_RST;
            s3_q   <= SYNC_RST;
            filt_q <= SYNC_RST;
            prev_q <= SYNC_RST;
        end else begin
            s1_q   <= pin_raw;
            s2_q   <= s1_q;
            s3_q   <= s2_q;
            filt_q <= filt_d;
            prev_q <= filt_q;
        end
    end

    logic sclk_rise, sclk_fall, sel_fall, conv_fall, sel_high, conv_high;
    assign sclk_rise = filt_q[L_SCLK] & ~prev_q[L_SCLK];
    assign sclk_fall = ~filt_q[L_SCLK] & prev_q[L_SCLK];
    assign sel_fall  = ~filt_q[L_CS_SEL] & prev_q[L_CS_SEL];
    assign conv_fall = ~filt_q[L_CS_CONV] & prev_q[L_CS_CONV];
    assign sel_high  = filt_q[L_CS_SEL];
    assign conv_high = filt_q[L_CS_CONV];

    // ****************************************************************
    // selector: word capture and break-before-make
    // ****************************************************************
    logic [WORD_W-1:0] word_q, word_d, latched_q, latched_d;
    logic [NUM_CH-1:0] chan_q, chan_d, chan_pick;
    logic [7:0]        sw_tmr_q, sw_tmr_d;
    mac_sw_e           sw_q, sw_d;

    // decode of the latched word, one term per channel
    generate
        for (gi = 0; gi < NUM_CH; gi++) begin : g_dec
            assign chan_pick[gi] = latched_q[WORD_EN_BIT]                                    // [R2]
                                 && (latched_q[WORD_ADDR_HI:0] == 3'(gi))                    // [R1]
                                 && (EIGHT_CHANNELS || (gi < NUM_CH_SMALL));                 // [R1]
        end
    endgenerate

    always_comb begin
        word_d    = word_q;
        latched_d = latched_q;
        chan_d    = chan_q;
        sw_tmr_d  = sw_tmr_q;
        sw_d      = sw_q;
        if (sel_high && sclk_rise) begin
            word_d = {word_q[WORD_W-2:0], filt_q[L_DIN]};  // [R15] [R16] [R8]
        end
        if (sel_fall) begin
            latched_d = word_q;                            // [R14]
            sw_tmr_d  = TMR_RST;
            sw_d      = SW_WAIT_OFF;                       // [R17]
        end else begin
            unique case (sw_q)
                SW_HOLD: begin
                    sw_tmr_d = TMR_RST;
                end
                SW_WAIT_OFF: begin
                    sw_tmr_d = sw_tmr_q + 8'h01;
                    if (sw_tmr_d >= SWITCH_OFF_CYC) begin
                        chan_d = '0;                       // [R14]
                        sw_d   = SW_WAIT_ON;
                    end
                end
                SW_WAIT_ON: begin
                    sw_tmr_d = sw_tmr_q + 8'h01;
                    if (sw_tmr_d >= CHANNEL_SETTLE_CYC) begin
                        chan_d = chan_pick;                // [R14] [R2]
                        sw_d   = SW_HOLD;
                    end
                end
            endcase
        end
    end

    // selector state registers
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            word_q    <= WORD_RST;
            latched_q <= WORD_RST;
            chan_q    <= '0;
            sw_tmr_q  <= TMR_RST;
            sw_q      <= SW_HOLD;
        end else begin
            word_q    <= word_d;
            latched_q <= latched_d;
            chan_q    <= chan_d;
            sw_tmr_q  <= sw_tmr_d;
            sw_q      <= sw_d;
        end
    end

    assign channel_on = chan_q;

    // ****************************************************************
    // converter: sample, successive approximation, serial return
    // ****************************************************************
    mac_cv_e           cv_q, cv_d;
    logic [7:0]        cv_tmr_q, cv_tmr_d;
    logic              fell_once_q, fell_once_d;
    logic              smp_q, smp_d;
    logic [RES_W-1:0]  code_q, code_d;
    logic [3:0]        idx_q, idx_d;
    logic              dout_q, dout_d, oe_q, oe_d;

    always_comb begin
        cv_d        = cv_q;
        cv_tmr_d    = cv_tmr_q;
        fell_once_d = fell_once_q;
        smp_d       = smp_q;
        code_d      = code_q;
        idx_d       = idx_q;
        dout_d      = dout_q;
        oe_d        = oe_q;
        if (conv_high) begin
            cv_d  = CV_DOWN;                               // [R8]
            smp_d = 1'b0;
            oe_d  = 1'b0;                                  // [R18]
        end else if (conv_fall || cv_q == CV_DOWN) begin
            cv_d        = CV_SAMPLE;                       // [R6]
            cv_tmr_d    = TMR_RST;
            fell_once_d = 1'b0;
            smp_d       = 1'b0;
            dout_d      = 1'b0;
        end else begin
            unique case (cv_q)
                CV_SAMPLE: begin
                    if (cv_tmr_q < CHANNEL_SETTLE_CYC) begin
                        cv_tmr_d = cv_tmr_q + 8'h01;
                    end else begin
                        smp_d = 1'b1;                      // [R9]
                    end
                    if (sclk_fall) begin
                        oe_d   = 1'b1;                     // [R4]
                        dout_d = 1'b0;
                        if (fell_once_q) begin
                            smp_d  = 1'b0;                 // [R9] [R11] [R12]
                            cv_d   = CV_CONVERT;
                            code_d = {1'b1, {(RES_W-1){1'b0}}};
                            idx_d  = LAST_BIT_IDX;         // [R17] null bit now on the wire
                        end else begin
                            fell_once_d = 1'b1;
                        end
                    end
                end
                CV_CONVERT: begin
                    if (sclk_fall) begin
                        code_d[idx_q] = filt_q[L_CMP];     // [R3]
                        dout_d        = filt_q[L_CMP];     // [R18] [R16]
                        if (idx_q == 4'h0) begin
                            cv_d  = CV_TAIL;               // [R10] [R7]
                            idx_d = 4'h1;
                        end else begin
                            code_d[idx_q - 4'h1] = 1'b1;
                            idx_d = idx_q - 4'h1;
                        end
                    end
                end
                CV_TAIL: begin
                    if (sclk_fall) begin
                        if (idx_q < TAIL_END) begin
                            dout_d = code_q[idx_q];        // [R7] [R18]
                            idx_d  = idx_q + 4'h1;
                        end else begin
                            dout_d = 1'b0;                 // [R7]
                        end
                    end
                end
                CV_DOWN: begin
                    smp_d = 1'b0;
                end
            endcase
        end
    end

    // converter state registers
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cv_q        <= CV_DOWN;
            cv_tmr_q    <= TMR_RST;
            fell_once_q <= 1'b0;
            smp_q       <= 1'b0;
            code_q      <= CODE_RST;
            idx_q       <= 4'h0;
            dout_q      <= 1'b0;
            oe_q        <= 1'b0;
        end else begin
            cv_q        <= cv_d;
            cv_tmr_q    <= cv_tmr_d;
            fell_once_q <= fell_once_d;
            smp_q       <= smp_d;
            code_q      <= code_d;
            idx_q       <= idx_d;
            dout_q      <= dout_d;
            oe_q        <= oe_d;
        end
    end

    // analogue core controls follow the converter state
    assign sample_on             = smp_q;
    assign cap_to_negative_input = (cv_q == CV_CONVERT);                          // [R12]
    assign converter_power_on    = (cv_q == CV_SAMPLE) || (cv_q == CV_CONVERT);   // [R7] [R8]
    assign reference_connect     = converter_power_on;                            // [R7]
    assign dac_trial_code        = code_q;
    assign serial_out            = dout_q;
    assign serial_out_oe         = oe_q & ~conv_high;                             // [R18]

endmodule : mac_muxed_adc_ctrl
`default_nettype wire

// >>> mac_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// host serial port model
// ****
module mac_host_model #(
    parameter int HALF = 80
) (
    // clock
    input  wire logic        sys_clk,
    // device data pins
    input  wire logic        serial_out,
    input  wire logic        serial_out_oe,
    // host pins
    output logic             shift_clk,
    output logic             serial_in,
    output logic             sel_n,
    output logic             conv_n,
    // captured frame
    output logic             done,
    output logic [24:0]      frame
);
    logic hbit = 1'b0;
    logic flip = 1'b0;
    // released wire toggles so no stale level survives
    always @(posedge sys_clk) flip <= ~flip;
    // shared wire, host drives only while both selects high
    assign serial_in = serial_out_oe ? serial_out : (sel_n & conv_n) ? hbit : flip;
    // idle pins
    initial begin
        shift_clk = 1'b0;
        sel_n = 1'b1;
        conv_n = 1'b1;
        done = 1'b0;
        frame = '0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : tick
    // one exchange: six bits clocked in, then a converter frame
    task automatic xfer(input logic [5:0] bits, input bit both);
        if (both) begin
            sel_n = 1'b1;
        end
        conv_n = 1'b1;
        tick(HALF);
        for (int i = 5; i >= 0; i--) begin
            hbit = bits[i];
            tick(HALF);
            shift_clk = 1'b1;
            tick(HALF);
            shift_clk = 1'b0;
        end
        tick(HALF);
        sel_n = 1'b0;
        conv_n = 1'b0;
        frame = '0;
        tick(HALF);
        for (int k = 0; k <= 26; k++) begin
            shift_clk = 1'b1;
            if (k >= 2) begin
                frame = {frame[23:0], serial_in};
            end
            tick(HALF);
            shift_clk = 1'b0;
            tick(HALF);
        end
        conv_n = 1'b1;
        done = 1'b1;
        tick(1);
        done = 1'b0;
    endtask : xfer
endmodule : mac_host_model
`default_nettype wire

// >>> mac_muxed_adc_ctrl_props.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// port checker
// ****
module mac_muxed_adc_ctrl_props
    import mac_pkg::*;
#(
    parameter bit EIGHT_CHANNELS = 1'b1
) (
    input wire logic              sys_clk,
    input wire logic              rstn,
    input wire logic              selector_chip_select_n,
    input wire logic              converter_chip_select_n,
    input wire logic              shift_clk,
    input wire logic              serial_out_oe,
    input wire logic [NUM_CH-1:0] channel_on,
    input wire logic              sample_on,
    input wire logic              cap_to_negative_input,
    input wire logic              converter_power_on,
    input wire logic              reference_connect
);
    logic       clk_q, fell;
    logic [4:0] fall_q, fall_d, conv_q, conv_d;
    // count raw shift falls in the frame and in conversion
    always_comb begin
        fell = clk_q & ~shift_clk;
        fall_d = converter_chip_select_n ? 5'h00 : fall_q + 5'(fell && fall_q != 5'h1F);
        conv_d = cap_to_negative_input ? conv_q + 5'(fell) : 5'h00;
    end
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            clk_q <= 1'b0;
            fall_q <= 5'h00;
            conv_q <= 5'h00;
        end else begin
            clk_q <= shift_clk;
            fall_q <= fall_d;
            conv_q <= conv_d;
        end
    end
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rstn);
    a_oe_by_sixth: assert property (fall_q == 5'h06 && !converter_chip_select_n |-> serial_out_oe)
        else $error("data wire not driven by sixth fall");
    a_oe_off_idle: assert property (converter_chip_select_n [*8] |-> !serial_out_oe)
        else $error("data wire driven while deselected");
    a_idle_power_down: assert property (converter_chip_select_n [*8] |-> !converter_power_on && !sample_on)
        else $error("converter powered while deselected");
    a_one_channel: assert property ($onehot0(channel_on) && (EIGHT_CHANNELS || channel_on[7:4] == 4'h0))
        else $error("bad channel switch pattern");
    a_hold_to_neg: assert property ($fell(sample_on) && !converter_chip_select_n |-> cap_to_negative_input)
        else $error("hold did not start conversion");
    a_no_overlap: assert property (!(sample_on && cap_to_negative_input))
        else $error("sampling during conversion");
    a_conv_twelve: assert property ($fell(cap_to_negative_input) && !converter_chip_select_n
        |-> conv_q == 5'(CONV_CYCLES)) else $error("conversion length wrong");
    a_ref_with_power: assert property (converter_power_on == reference_connect)
        else $error("reference and power differ");
    a_ref_released: assert property (fall_q == 5'h10 && !converter_chip_select_n |-> !reference_connect)
        else $error("reference held after conversion");
    a_down_after_conv: assert property ($fell(cap_to_negative_input) |-> ##[0:2] !converter_power_on)
        else $error("no power down after conversion");
    a_break_first: assert property ($fell(selector_chip_select_n) |-> ##[1:14] channel_on == 8'h00)
        else $error("no break before make");
endmodule : mac_muxed_adc_ctrl_props
bind mac_muxed_adc_ctrl mac_muxed_adc_ctrl_props #(.EIGHT_CHANNELS(EIGHT_CHANNELS)) u_props (.sys_clk, .rstn,
    .selector_chip_select_n, .converter_chip_select_n, .shift_clk, .serial_out_oe, .channel_on, .sample_on,
    .cap_to_negative_input, .converter_power_on, .reference_connect);
`default_nettype wire

// >>> tb_mac_muxed_adc_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// testbench
// ****
module tb_mac_muxed_adc_ctrl
    import mac_pkg::*;
();
    logic             sys_clk = 1'b0;
    logic             rstn = 1'b0;
    logic [RES_W-1:0] vin = '0;
    logic [40:0]      exp_q[$];
    int               miscompares = 0;
    int               n_checks = 0;
    wire logic        sclk, sdi, sel_n, conv_n, sdo, oe, done, smp, cneg, pwr, refc;
    wire logic [7:0]  chan, chan4;
    wire logic [11:0] dac;
    wire logic [24:0] frame;
    // ideal comparator against the trial code
    wire logic        cmp = (vin >= dac);
    mac_muxed_adc_ctrl dut (.sys_clk(sys_clk), .rstn(rstn), .selector_chip_select_n(sel_n),
        .converter_chip_select_n(conv_n), .shift_clk(sclk), .serial_in(sdi), .serial_out(sdo),
        .serial_out_oe(oe), .channel_on(chan), .comparator_high(cmp), .sample_on(smp),
        .cap_to_negative_input(cneg), .converter_power_on(pwr), .reference_connect(refc), .dac_trial_code(dac));
    mac_host_model host (.sys_clk(sys_clk), .serial_out(sdo), .serial_out_oe(oe), .shift_clk(sclk),
        .serial_in(sdi), .sel_n(sel_n), .conv_n(conv_n), .done(done), .frame(frame));
    // four-input variant on the same pins, only its switches are compared
    mac_muxed_adc_ctrl #(.EIGHT_CHANNELS(1'b0)) dut_small (.sys_clk(sys_clk), .rstn(rstn),
        .selector_chip_select_n(sel_n), .converter_chip_select_n(conv_n), .shift_clk(sclk), .serial_in(sdi),
        .serial_out(), .serial_out_oe(), .channel_on(chan4), .comparator_high(cmp), .sample_on(),
        .cap_to_negative_input(), .converter_power_on(), .reference_connect(), .dac_trial_code());
    initial forever #10 sys_clk = ~sys_clk;
    task automatic check(input string what, input logic [40:0] seen, input logic [40:0] expv);
        n_checks++;
        if (seen !== expv) begin
            miscompares++;
            $display("Error %s expected %h seen %h", what, expv, seen);
        end
    endtask : check
    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : test_done
    // null bit, msb-first code, lsb-first copy, trailing zero
    function automatic logic [24:0] exp_frame(input logic [11:0] c);
        logic [24:0] f;
        f = {1'b0, c, 12'h000};
        for (int i = 1; i < 12; i++) begin
            f[12-i] = c[i];
        end
        return f;
    endfunction : exp_frame
    task automatic run(input logic [3:0] w, input bit both, input logic [11:0] v, input logic [7:0] ch);
        vin = v;
        exp_q.push_back({4'h0, ch[3:0], ch, exp_frame(v)});
        host.xfer({2'($urandom), w}, both);
    endtask : run
    // compare each finished frame and the switches
    always @(posedge sys_clk) begin
        if (done === 1'b1) begin
            check("frame", {chan4, chan, frame}, exp_q.pop_front());
        end
    end
    // watchdog
    initial begin
        repeat (95000) @(posedge sys_clk);
        miscompares++;
        test_done();
    end
    // main sequence
    initial begin
        void'($urandom(32'hB95F));
        repeat (2) @(posedge sys_clk);
        #1;
        rstn = 1'b1;
        repeat (8) @(posedge sys_clk);
        #1;
        for (int c = 0; c < 8; c++) begin
            run({1'b1, 3'(c)}, 1'b1, (c == 0) ? 12'h000 : (c == 1) ? 12'h001 : (c == 2) ? 12'hFFF : 12'($urandom),
                8'h01 << c);
        end
        run({1'b0, 3'($urandom)}, 1'b1, 12'($urandom), 8'h00);
        run(4'hD, 1'b1, 12'h5A5, 8'h20);
        repeat (2) run(4'($urandom), 1'b0, 12'($urandom), 8'h20);
        repeat (4) @(posedge sys_clk);
        check("queue empty", 41'(exp_q.size()), 41'h0);
        test_done();
    end
endmodule : tb_mac_muxed_adc_ctrl
`default_nettype wire
